// *** logic/alp_addr_load_port_out.sv ***
// Purpose: decode and execute pointer loads and port 0/1 output writes
// Assumes: one instruction word per valid cycle from program memory, same clock
// Notes:   accumulator is only read here, never written back
//          the load run survives invalid cycles, so a stall never re-arms a load
//          unknown words only pulse done and close an open load run
//          reset closes the run, so the first load after reset executes
`timescale 1ns/1ns
module alp_addr_load_port_out (
	input  wire logic                          clock_i,
	input  wire logic                          reset_i,
	input  wire logic                          instr_valid_i,
	input  wire logic [alp_pkg::ALP_IW-1:0]    instr_i,
	input  wire logic [alp_pkg::ALP_DW-1:0]    acc_i,
	output logic      [alp_pkg::ALP_DW-1:0]    row_ptr_o,
	output logic      [alp_pkg::ALP_DW-1:0]    col_ptr_o,
	output logic      [alp_pkg::ALP_ZW-1:0]    bank_ptr_o,
	output logic      [alp_pkg::ALP_DW-1:0]    output_port_zero_o,
	output logic      [alp_pkg::ALP_DW-1:0]    output_port_one_o,
	output logic                               skipped_o,
	output logic                               done_o
);
	import alp_pkg::*;

	localparam int NUM_PORTS = 2;

	// decoded class of the word on instr_i
	typedef enum logic [2:0] {
		ALP_OP_OTHER                = 3'h0,
		ALP_OP_NOP                  = 3'h1,
		ALP_OP_LOAD_ROW_COL_POINTER = 3'h2,
		ALP_OP_LOAD_BANK_POINTER    = 3'h3,
		ALP_OP_OUT_PORT0_FROM_ACC   = 3'h4,
		ALP_OP_OUT_PORT1_FROM_ACC   = 3'h5
	} alp_op_e;

	// row/column load run: open after an executed or skipped load
	typedef enum logic {
		ALP_RUN_IDLE   = 1'b0,
		ALP_RUN_LOADED = 1'b1
	} alp_run_e;

	alp_op_e                          op;
	logic                             row_col_hit;
	logic                             bank_hit;
	logic                             take_row_col;
	logic                             take_bank;
	logic [NUM_PORTS-1:0]             port_write;
	wire  [NUM_PORTS-1:0][ALP_DW-1:0] port_q;

	logic [ALP_DW-1:0]                row_q,  row_d;
	logic [ALP_DW-1:0]                col_q,  col_d;
	logic [ALP_ZW-1:0]                bank_q, bank_d;
	alp_run_e                         run_q,  run_d;
	logic                             skip_q, skip_d;
	logic                             done_q, done_d;

	// classify the word; immediate fields are masked before matching
	always_comb begin
		// row/column loads own the whole upper quarter of the code space
		row_col_hit = (instr_i & ALP_ROW_COL_LOAD_MASK) == ALP_ROW_COL_LOAD_CODE;
		bank_hit    = (instr_i & ALP_BANK_LOAD_MASK) == ALP_BANK_LOAD_CODE;
		op          = ALP_OP_OTHER;
		if (row_col_hit) begin
			op = ALP_OP_LOAD_ROW_COL_POINTER;
		end else if (bank_hit) begin
			op = ALP_OP_LOAD_BANK_POINTER;
		end else if (instr_i == ALP_OP0_CODE) begin
			op = ALP_OP_OUT_PORT0_FROM_ACC;
		end else if (instr_i == ALP_OP1_CODE) begin
			op = ALP_OP_OUT_PORT1_FROM_ACC;
		end else if (instr_i == ALP_NOP_CODE) begin
			op = ALP_OP_NOP;
		end
	end

	// strobes are gated by valid so a stalled word writes nothing
	always_comb begin
		take_bank     = instr_valid_i && (op == ALP_OP_LOAD_BANK_POINTER);
		port_write[0] = instr_valid_i && (op == ALP_OP_OUT_PORT0_FROM_ACC);
		port_write[1] = instr_valid_i && (op == ALP_OP_OUT_PORT1_FROM_ACC);
	end

	// run state: an executed or skipped load keeps it open, any other valid word closes it
	always_comb begin
		run_d        = run_q;
		take_row_col = 1'b0;
		// idle cycles leave the run alone: a stall must not re-arm a load
		if (instr_valid_i) begin
			unique case (run_q)
				ALP_RUN_IDLE: begin
					if (op == ALP_OP_LOAD_ROW_COL_POINTER) begin
						run_d        = ALP_RUN_LOADED;
						take_row_col = 1'b1;
					end
				end
				ALP_RUN_LOADED: begin
					// a skipped load leaves the run open, so a third load is skipped too
					if (op != ALP_OP_LOAD_ROW_COL_POINTER) begin
						run_d = ALP_RUN_IDLE;
					end
				end
			endcase
		end
	end

	// reset closes the run so the first load after reset executes
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			run_q <= ALP_RUN_IDLE;
		end else begin
			run_q <= run_d;
		end
	end

	// skip pulse: a row/column load met while the run is open
	always_comb begin
		skip_d = 1'b0;
		if (instr_valid_i && (run_q == ALP_RUN_LOADED)) begin
			skip_d = (op == ALP_OP_LOAD_ROW_COL_POINTER);
		end
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			skip_q <= 1'b0;
		end else begin
			skip_q <= skip_d;
		end
	end

	// row and column pointers take the two nibbles of one word
	always_comb begin
		row_d = row_q;
		col_d = col_q;
		if (take_row_col) begin
			row_d = instr_i[ALP_X_LSB +: ALP_DW];
			col_d = instr_i[ALP_Y_LSB +: ALP_DW];
		end
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			row_q <= ALP_PTR_RST;
			col_q <= ALP_PTR_RST;
		end else begin
			row_q <= row_d;
			col_q <= col_d;
		end
	end

	// bank pointer is two bits wide, so its field cannot exceed 3
	always_comb begin
		bank_d = bank_q;
		if (take_bank) begin
			bank_d = instr_i[ALP_Z_LSB +: ALP_ZW];
		end
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			bank_q <= ALP_BANK_RST;
		end else begin
			bank_q <= bank_d;
		end
	end

	// one latch per output port; the accumulator is only sampled, never written back
	for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
		logic [ALP_DW-1:0] latch_d;
		logic [ALP_DW-1:0] latch_q;

		always_comb begin
			latch_d = latch_q;
			if (port_write[g]) begin
				latch_d = acc_i;
			end
		end

		always_ff @(posedge clock_i or posedge reset_i) begin
			if (reset_i) begin
				latch_q <= ALP_PORT_RST;
			end else begin
				latch_q <= latch_d;
			end
		end

		assign port_q[g] = latch_q;
	end

	// unknown words and the all-zero word still finish in one cycle
	always_comb begin
		done_d = instr_valid_i;
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			done_q <= 1'b0;
		end else begin
			done_q <= done_d;
		end
	end

	// every output is a register, no logic after the flops
	assign row_ptr_o          = row_q;
	assign col_ptr_o          = col_q;
	assign bank_ptr_o         = bank_q;
	assign output_port_zero_o = port_q[0];
	assign output_port_one_o  = port_q[1];
	assign skipped_o          = skip_q;
	assign done_o             = done_q;
endmodule : alp_addr_load_port_out

// *** logic/alp_pkg.sv ***
// Purpose: constants for the pointer-load and port-output decoder
// Assumes: 10-bit instruction words, 4-bit data path
// Notes:   opcode patterns are compared after masking the immediate fields
package alp_pkg;
	localparam int          ALP_IW         = 10;
	localparam int          ALP_DW         = 4;
	localparam int          ALP_ZW         = 2;
	// row/column load: 11 xxxx yyyy
	localparam logic [9:0]  ALP_ROW_COL_LOAD_MASK = 10'h300;
	localparam logic [9:0]  ALP_ROW_COL_LOAD_CODE = 10'h300;
	localparam int          ALP_X_LSB      = 4;
	localparam int          ALP_Y_LSB      = 0;
	// bank load: 00 0100 10zz
	localparam logic [9:0]  ALP_BANK_LOAD_MASK = 10'h3fc;
	localparam logic [9:0]  ALP_BANK_LOAD_CODE = 10'h048;
	localparam int          ALP_Z_LSB      = 0;
	// port outputs and nop
	localparam logic [9:0]  ALP_OP0_CODE   = 10'h220;
	localparam logic [9:0]  ALP_OP1_CODE   = 10'h221;
	localparam logic [9:0]  ALP_NOP_CODE   = 10'h000;
	// reset values
	localparam logic [3:0]  ALP_PTR_RST    = 4'h0;
	localparam logic [1:0]  ALP_BANK_RST   = 2'h0;
	localparam logic [3:0]  ALP_PORT_RST   = 4'h0;
endpackage : alp_pkg

// *** testbench/alp_pm_model.sv ***
// Purpose: program memory model
// Assumes: eight words
// Notes:   async read
`timescale 1ns/1ns
module alp_pm_model (
	input  wire logic [2:0] addr_i,
	output logic      [9:0] word_o
);
	// word 0 is the last entry of the concatenation
	localparam logic [79:0] ROM = {10'h048,10'h000,10'h3f0,10'h221,10'h220,10'h04b,10'h312,10'h3a5};
	assign word_o = ROM[addr_i*10+:10];
endmodule : alp_pm_model

// *** testbench/alp_addr_load_port_out_assertions.sv ***
// Purpose: decoder checks
// Assumes: alp_pkg codes
// Notes:   bound below
`timescale 1ns/1ns
module alp_chk
	import alp_pkg::*;
(
	input  wire logic       clock_i,
	input  wire logic       reset_i,
	input  wire logic       instr_valid_i,
	input  wire logic [9:0] instr_i,
	input  wire logic [3:0] acc_i,
	input  wire logic [3:0] row_ptr_o,
	input  wire logic [3:0] col_ptr_o,
	input  wire logic [1:0] bank_ptr_o,
	input  wire logic [3:0] output_port_zero_o,
	input  wire logic [3:0] output_port_one_o,
	input  wire logic       skipped_o,
	input  wire logic       done_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);
	logic      run_open_q;
	wire       valid      = instr_valid_i;
	wire       row_col_ld = valid && ((instr_i & ALP_ROW_COL_LOAD_MASK) == ALP_ROW_COL_LOAD_CODE);
	wire       bank_ld    = valid && ((instr_i & ALP_BANK_LOAD_MASK) == ALP_BANK_LOAD_CODE);
	wire [7:0] rc         = {row_ptr_o, col_ptr_o};
	// open after any row/column load, closed by any other valid word
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			run_open_q <= 1'b0;
		end else if (valid) begin
			run_open_q <= row_col_ld;
		end
	end
	sequence s_run;
		row_col_ld ##1 row_col_ld;
	endsequence
	sequence s_first;
		row_col_ld && !run_open_q;
	endsequence
	a_row_col: assert property (s_first |=> !skipped_o && rc == $past(instr_i[7:0]))
		else $error("row and column not loaded");
	a_skip_run: assert property (s_run |=> skipped_o && $stable(rc))
		else $error("back to back load not skipped");
	a_skip_gap: assert property (row_col_ld && run_open_q |=> skipped_o && $stable(rc))
		else $error("load after stall not skipped");
	a_skip_only: assert property (!row_col_ld |=> !skipped_o)
		else $error("skip without a load");
	a_bank_load: assert property (bank_ld |=> bank_ptr_o == $past(instr_i[1:0]))
		else $error("bank not loaded");
	a_port_zero: assert property (valid && instr_i == ALP_OP0_CODE
		|=> output_port_zero_o == $past(acc_i)) else $error("port zero not written");
	a_port_one: assert property (valid && instr_i == ALP_OP1_CODE
		|=> output_port_one_o == $past(acc_i)) else $error("port one not written");
	a_nop_still: assert property (valid && instr_i == ALP_NOP_CODE
		|=> done_o && $stable(rc) && $stable(bank_ptr_o)
		&& $stable(output_port_zero_o) && $stable(output_port_one_o)) else $error("nop moved state");
	a_done_pulse: assert property (valid |=> done_o)
		else $error("taken word without done");
	a_done_idle: assert property (!valid |=> !done_o)
		else $error("done without a word");
endmodule : alp_chk
bind alp_addr_load_port_out alp_chk i_chk (
	.clock_i            (clock_i),
	.reset_i            (reset_i),
	.instr_valid_i      (instr_valid_i),
	.instr_i            (instr_i),
	.acc_i              (acc_i),
	.row_ptr_o          (row_ptr_o),
	.col_ptr_o          (col_ptr_o),
	.bank_ptr_o         (bank_ptr_o),
	.output_port_zero_o (output_port_zero_o),
	.output_port_one_o  (output_port_one_o),
	.skipped_o          (skipped_o),
	.done_o             (done_o)
);

// *** testbench/alp_addr_load_port_out_tb_top.sv ***
// Purpose: decoder bench
// Assumes: 100 MHz clock
// Notes:   rows, run across a gap, reset
`timescale 1ns/1ns
module alp_addr_load_port_out_tb_top;
	logic clock_i = 0, reset_i = 1, instr_valid_i = 0;
	logic [2:0] pc = 0;
	logic [3:0] acc_i = 0;
	logic [9:0] instr_i;
	wire [19:0] got;
	int mismatches = 0, n_compared = 0;
	logic [23:0] rows [8] = '{24'hca5100, 24'hca5300, 24'hca5d00, 24'h7a5d70, 24'h9a5d79,
		24'hcf0d79, 24'hcf0d79, 24'hcf0179};
	alp_pm_model i_alp_pm_model (.addr_i(pc), .word_o(instr_i));
	alp_addr_load_port_out i_alp_addr_load_port_out (.clock_i, .reset_i, .instr_valid_i,
		.instr_i, .acc_i, .row_ptr_o(got[19:16]), .col_ptr_o(got[15:12]), .skipped_o(got[9]),
		.bank_ptr_o(got[11:10]), .done_o(got[8]), .output_port_zero_o(got[7:4]),
		.output_port_one_o(got[3:0]));
	initial forever #5 clock_i = ~clock_i;
	task chk(input logic [19:0] e);
		n_compared++;
		if (got !== e) begin mismatches++; $display("MISMATCH %0t got %h exp %h", $time, got, e); end
	endtask : chk
	task step(input logic [2:0] a, input logic e);
		pc = a; instr_valid_i = e; @(posedge clock_i) #1;
	endtask : step
	task print_verdict;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (3) @(posedge clock_i);
		#1 reset_i = 0; @(posedge clock_i) #1;
		for (int i = 0; i < 8; i++) begin
			acc_i = rows[i][23:20];
			step(3'(i), 1'b1);
			chk(rows[i][19:0]);
		end
		step(3'h0, 1'b1);
		step(3'h0, 1'b0);
		chk(20'ha5079);
		step(3'h1, 1'b1);
		chk(20'ha5379);
		reset_i = 1;
		instr_valid_i = 0;
		#2 chk(20'h0);
		@(posedge clock_i) #1 reset_i = 0;
		@(posedge clock_i) #1 chk(20'h0);
		step(3'h1, 1'b1);
		chk(20'h12100);
		print_verdict;
	end
endmodule : alp_addr_load_port_out_tb_top
